// ---- logic/nvmseq_core.sv ----
// Command sequencer: latches, row writes, row and bulk erase, protection.
// Assumes framed commands and data arrive as one-cycle strobes; the serial
// clock level is given as a pin and is synchronised here.
`timescale 1ns/100ps
module nvmseq_core (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic link_clk,
  input wire logic cmd_valid,
  input wire logic [5:0] cmd_code,
  input wire logic [15:0] cmd_data,
  input wire logic [15:0] panel_mask,
  input wire logic target_is_config,
  output logic busy,
  output logic [15:0] addr,
  output logic [13:0] read_data,
  output logic link_clk_edge,
  output logic program_protect_n,
  output logic eeprom_protect_n,
  output logic mem_write,
  output logic mem_write_eeprom,
  output logic [15:0] mem_row_addr,
  output logic [13:0] mem_word,
  output logic [4:0] mem_word_idx,
  output logic row_erase,
  output logic erase_pm,
  output logic erase_ee,
  output logic erase_uid,
  output logic erase_cfg,
  output logic erase_cfg4
);

  nvmseq_pkg::nvmseq_state_t state;
  nvmseq_pkg::nvmseq_state_t next_state;
  logic [13:0] latch [nvmseq_pkg::FLASH_ROW_WORDS];
  logic [nvmseq_pkg::TIMER_W-1:0] timer;
  logic [nvmseq_pkg::TIMER_W-1:0] next_timer;
  logic [5:0] write_idx;
  logic ext_blocked;
  logic link_sync1;
  logic link_sync2;
  logic link_prev;
  logic bulk_cfg_pending;

  // ----------------------------------------------------------------
  // Link clock sampling
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      link_sync1 <= 1'b0;
      link_sync2 <= 1'b0;
      link_prev <= 1'b0;
      link_clk_edge <= 1'b0;
    end else begin
      link_sync1 <= link_clk;
      link_sync2 <= link_sync1;
      link_prev <= link_sync2;
      link_clk_edge <= link_prev & ~link_sync2;
    end
  end

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  function automatic logic in_range(input logic [15:0] a, input logic [15:0] lo, input logic [15:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction

  wire idle = (state == nvmseq_pkg::NVMSEQ_IDLE);
  wire take = cmd_valid && idle;
  wire is_load_cfg = take && (cmd_code == nvmseq_pkg::CMD_LOAD_CONFIG);
  wire is_load_data = take && ((cmd_code == nvmseq_pkg::CMD_LOAD_DATA) ||
                               (cmd_code == nvmseq_pkg::CMD_LOAD_DATA_INC));
  wire is_read = take && ((cmd_code == nvmseq_pkg::CMD_READ_DATA) ||
                          (cmd_code == nvmseq_pkg::CMD_READ_DATA_INC));
  wire is_inc = take && (cmd_code == nvmseq_pkg::CMD_INCREMENT);
  wire is_load_addr = take && (cmd_code == nvmseq_pkg::CMD_LOAD_ADDR);
  wire is_begin_int = take && (cmd_code == nvmseq_pkg::CMD_BEGIN_INT);
  wire is_begin_ext = take && (cmd_code == nvmseq_pkg::CMD_BEGIN_EXT);
  wire is_end = cmd_valid && (cmd_code == nvmseq_pkg::CMD_END_PROG);
  wire is_bulk = take && (cmd_code == nvmseq_pkg::CMD_BULK_ERASE);
  wire is_row_erase = take && (cmd_code == nvmseq_pkg::CMD_ROW_ERASE);
  // Codes other than the above fall through with no effect
  wire auto_inc = take && cmd_code[5] && (is_load_data || is_read);
  wire [15:0] pc = addr;
  wire [15:0] load_addr = is_load_cfg ? nvmseq_pkg::ADDR_CONFIG_BASE : cmd_data;

  // ----------------------------------------------------------------
  // Region and protection decode
  // ----------------------------------------------------------------
  wire pc_main = in_range(pc, nvmseq_pkg::ADDR_RESET, nvmseq_pkg::ADDR_MAIN_TOP);
  wire pc_eeprom = in_range(pc, nvmseq_pkg::ADDR_EE_BASE, nvmseq_pkg::ADDR_ALL_TOP);
  wire pc_userid = in_range(pc, nvmseq_pkg::ADDR_CONFIG_BASE, nvmseq_pkg::ADDR_USERID_TOP);
  wire pc_cfg_space = in_range(pc, nvmseq_pkg::ADDR_CONFIG_BASE, nvmseq_pkg::ADDR_BE_PM_TOP);
  wire any_protect = ~program_protect_n | ~eeprom_protect_n;
  wire main_locked = pc_main && ~program_protect_n;
  wire ee_locked = pc_eeprom && ~eeprom_protect_n;
  wire cfg_target = pc_cfg_space && target_is_config;

  wire be_r0 = pc_main;
  wire be_r1 = in_range(pc, nvmseq_pkg::ADDR_CONFIG_BASE, nvmseq_pkg::ADDR_BE_CFG_TOP);
  wire be_r2 = in_range(pc, 16'h8400, nvmseq_pkg::ADDR_BE_UID_TOP);
  wire be_r3 = in_range(pc, 16'h8500, nvmseq_pkg::ADDR_BE_PM_TOP);
  wire be_r4 = in_range(pc, nvmseq_pkg::ADDR_BE_ALL_BASE, nvmseq_pkg::ADDR_BE_ALL_TOP);
  wire be_r5 = pc_eeprom;
  wire be_pm = be_r0 | be_r1 | be_r2 | be_r3 | be_r4;
  wire be_ee = ((be_r0 | be_r1 | be_r2 | be_r3) & any_protect) | be_r4 | be_r5;
  wire be_uid = be_r1 | be_r2 | be_r4;
  wire be_cfg = be_r0 | be_r1 | be_r4;

  // Row erase: user IDs always, main array only when unprotected
  wire re_allowed = pc_userid || (pc_main ? program_protect_n : ~ee_locked);

  // Writes: blocked on protected panels, external writes skip configuration
  wire write_allowed = ~main_locked && ~ee_locked;
  wire [nvmseq_pkg::TIMER_W-1:0] int_write_cyc = cfg_target ?
      nvmseq_pkg::TIMER_W'(nvmseq_pkg::INT_WRITE_CFG_CYC) :
      nvmseq_pkg::TIMER_W'(nvmseq_pkg::INT_WRITE_PM_CYC);
  wire [4:0] row_words = pc_eeprom ? 5'(nvmseq_pkg::EE_ROW_WORDS - 1) :
      5'(nvmseq_pkg::FLASH_ROW_WORDS - 1);
  wire [4:0] latch_idx = pc[4:0];
  wire [13:0] load_word = pc_eeprom ? {6'h00, cmd_data[7:0]} : cmd_data[13:0];

  nvmseq_addr_counter u_addr (
    .core_clk(core_clk),
    .nrst(nrst),
    .inc(is_inc | auto_inc),
    .load(is_load_addr | is_load_cfg),
    .load_value(load_addr),
    .panel_mask(is_load_cfg ? 16'hffff : panel_mask),
    .addr(addr)
  );

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_timer = timer;
    case (state)
      nvmseq_pkg::NVMSEQ_IDLE: begin
        if (is_begin_int && write_allowed) begin
          next_state = nvmseq_pkg::NVMSEQ_INT_WRITE;
          next_timer = int_write_cyc;
        end else if (is_begin_ext && write_allowed) begin
          next_state = nvmseq_pkg::NVMSEQ_EXT_WRITE;
          next_timer = '0;
        end else if (is_row_erase && re_allowed) begin
          next_state = nvmseq_pkg::NVMSEQ_ROW_ERASE;
          next_timer = nvmseq_pkg::TIMER_W'(nvmseq_pkg::ROW_ERASE_CYC);
        end else if (is_bulk) begin
          next_state = nvmseq_pkg::NVMSEQ_BULK_ERASE;
          next_timer = nvmseq_pkg::TIMER_W'(nvmseq_pkg::BULK_ERASE_CYC);
        end
      end
      nvmseq_pkg::NVMSEQ_EXT_WRITE: begin
        if (is_end) begin
          next_state = nvmseq_pkg::NVMSEQ_IDLE;
        end
      end
      nvmseq_pkg::NVMSEQ_INT_WRITE,
      nvmseq_pkg::NVMSEQ_ROW_ERASE,
      nvmseq_pkg::NVMSEQ_BULK_ERASE: begin
        if (timer == '0) begin
          next_state = nvmseq_pkg::NVMSEQ_IDLE;
        end else begin
          next_timer = timer - 1'b1;
        end
      end
      default: begin
        next_state = nvmseq_pkg::NVMSEQ_IDLE;
      end
    endcase
  end

  wire start_write = idle && (next_state == nvmseq_pkg::NVMSEQ_INT_WRITE ||
                              next_state == nvmseq_pkg::NVMSEQ_EXT_WRITE);
  wire bulk_start = idle && (next_state == nvmseq_pkg::NVMSEQ_BULK_ERASE);
  wire bulk_done = (state == nvmseq_pkg::NVMSEQ_BULK_ERASE) && (timer == '0);

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      state <= nvmseq_pkg::NVMSEQ_IDLE;
      timer <= '0;
    end else begin
      state <= next_state;
      timer <= next_timer;
    end
  end

  // ----------------------------------------------------------------
  // Row data latches
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (is_load_data || is_load_cfg) begin
      latch[is_load_cfg ? 5'h00 : latch_idx] <= load_word;
    end
  end

  // ----------------------------------------------------------------
  // Row write streaming: one latch per cycle into the addressed row
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      write_idx <= 6'h20;
      ext_blocked <= 1'b0;
      mem_row_addr <= 16'h0000;
      mem_write_eeprom <= 1'b0;
      mem_write <= 1'b0;
      mem_word <= 14'h0000;
      mem_word_idx <= 5'h00;
    end else begin
      if (start_write) begin
        write_idx <= {1'b0, pc_eeprom ? latch_idx : 5'h00};
        mem_row_addr <= pc_eeprom ? pc : {pc[15:5], 5'h00};
        mem_write_eeprom <= pc_eeprom;
        ext_blocked <= is_begin_ext && cfg_target;
      end else if (!write_idx[5]) begin
        write_idx <= (write_idx[4:0] >= row_words || mem_write_eeprom) ? 6'h20 : write_idx + 6'h01;
      end
      mem_write <= !write_idx[5] && !start_write && !ext_blocked;
      mem_word <= latch[write_idx[4:0]];
      mem_word_idx <= write_idx[4:0];
    end
  end

  // ----------------------------------------------------------------
  // Erase strobes and protection bits
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      row_erase <= 1'b0;
      erase_pm <= 1'b0;
      erase_ee <= 1'b0;
      erase_uid <= 1'b0;
      erase_cfg <= 1'b0;
      erase_cfg4 <= 1'b0;
      bulk_cfg_pending <= 1'b0;
      program_protect_n <= 1'b1;
      eeprom_protect_n <= 1'b1;
    end else begin
      row_erase <= idle && (next_state == nvmseq_pkg::NVMSEQ_ROW_ERASE);
      erase_pm <= bulk_start && be_pm;
      erase_ee <= bulk_start && be_ee;
      erase_uid <= bulk_start && be_uid;
      erase_cfg <= bulk_start && be_cfg;
      if (bulk_start) begin
        bulk_cfg_pending <= be_cfg;
      end else if (bulk_done) begin
        bulk_cfg_pending <= 1'b0;
      end
      erase_cfg4 <= bulk_done && bulk_cfg_pending;
      if (bulk_done && bulk_cfg_pending) begin
        program_protect_n <= 1'b1;
        eeprom_protect_n <= 1'b1;
      end else if (mem_write && cfg_target && mem_word_idx == 5'h00 && pc[3:0] == 4'h0) begin
        program_protect_n <= program_protect_n & mem_word[0];
        eeprom_protect_n <= eeprom_protect_n & mem_word[1];
      end
    end
  end

  // ----------------------------------------------------------------
  // Status and read path
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      busy <= 1'b0;
      read_data <= 14'h0000;
    end else begin
      busy <= (next_state != nvmseq_pkg::NVMSEQ_IDLE);
      if (is_read) begin
        read_data <= main_locked ? 14'h0000 : latch[latch_idx];
      end
    end
  end

endmodule

// ---- logic/nvmseq_pkg.sv ----
// Constants shared by the command sequencer of the serial programming mode.
// Assumes a 250 MHz core clock and commands already framed into six-bit codes.
// Contract
// - Address counter only counts up; reset only by re-entering programming mode.
// - Increment wraps 7FFFh to 0000h and FFFFh to 8000h.
// - Load-address overwrites the counter; bits above the panel width are ignored.
// - Internal begin writes the row, self-timed, with no erase first.
// - External begin writes the row until the end command arrives.
// - External writes leave configuration and calibration words unchanged.
// - Bulk erase picks regions from address and protection, configuration word 4 last.
// - 0000h-7FFFh: program memory and configuration, plus EEPROM if protected.
// - 8000h-85FFh: program memory, user IDs, configuration by range; EEPROM if protected.
// - E800h-EFFFh erases everything; F000h-FFFFh erases EEPROM only.
// - Flash rows are 32 words; EEPROM rows are one byte.
// - Row erase of program memory is ignored under program protection.
// - Row erase at 8000h-800Ah clears only user IDs.
// - Row erase clears the addressed row, self-timed, no end command.
// - Each load fills one 14-bit latch; extra loads overwrite earlier latches.
// - Latches indexed by low address bits; begin address selects the row.
// - Program protection reads main array as zero and blocks its programming.
// - User IDs and configuration stay programmable and readable regardless of protection.
// - Protections enabled by writing active-low bits to 0; cleared only by bulk erase.
// - Six-bit commands: 06h, 1Dh, 08h, 18h, 0Ah, 09h, 05h.
// - Internal write finishes within 2.5 ms program, 5 ms configuration.
package nvmseq_pkg;

  localparam logic [5:0] CMD_LOAD_CONFIG = 6'h00;
  localparam logic [5:0] CMD_LOAD_DATA = 6'h02;
  localparam logic [5:0] CMD_LOAD_DATA_INC = 6'h22;
  localparam logic [5:0] CMD_READ_DATA = 6'h04;
  localparam logic [5:0] CMD_READ_DATA_INC = 6'h24;
  localparam logic [5:0] CMD_INCREMENT = 6'h06;
  localparam logic [5:0] CMD_LOAD_ADDR = 6'h1d;
  localparam logic [5:0] CMD_BEGIN_INT = 6'h08;
  localparam logic [5:0] CMD_BEGIN_EXT = 6'h18;
  localparam logic [5:0] CMD_END_PROG = 6'h0a;
  localparam logic [5:0] CMD_BULK_ERASE = 6'h09;
  localparam logic [5:0] CMD_ROW_ERASE = 6'h05;

  localparam logic [15:0] ADDR_CONFIG_BASE = 16'h8000;
  localparam logic [15:0] ADDR_MAIN_TOP = 16'h7fff;
  localparam logic [15:0] ADDR_ALL_TOP = 16'hffff;
  localparam logic [15:0] ADDR_USERID_TOP = 16'h800a;
  localparam logic [15:0] ADDR_BE_CFG_TOP = 16'h83ff;
  localparam logic [15:0] ADDR_BE_UID_TOP = 16'h84ff;
  localparam logic [15:0] ADDR_BE_PM_TOP = 16'h85ff;
  localparam logic [15:0] ADDR_BE_ALL_BASE = 16'he800;
  localparam logic [15:0] ADDR_BE_ALL_TOP = 16'hefff;
  localparam logic [15:0] ADDR_EE_BASE = 16'hf000;
  localparam logic [15:0] ADDR_RESET = 16'h0000;

  localparam int FLASH_ROW_WORDS = 32;
  localparam int EE_ROW_WORDS = 1;
  localparam int LATCH_IDX_W = 5;
  localparam int WORD_W = 14;
  localparam int EE_WORD_W = 8;
  localparam int ADDR_W = 16;

  localparam int CLK_MHZ = 250;
  localparam int INT_WRITE_PM_US = 2500;
  localparam int INT_WRITE_CFG_US = 5000;
  localparam int BULK_ERASE_US = 5000;
  localparam int ROW_ERASE_US = 2500;
  localparam int INT_WRITE_PM_CYC = INT_WRITE_PM_US * CLK_MHZ;
  localparam int INT_WRITE_CFG_CYC = INT_WRITE_CFG_US * CLK_MHZ;
  localparam int BULK_ERASE_CYC = BULK_ERASE_US * CLK_MHZ;
  localparam int ROW_ERASE_CYC = ROW_ERASE_US * CLK_MHZ;
  localparam int TIMER_W = 21;

  localparam logic [WORD_W-1:0] ERASED_WORD = 14'h3fff;

  typedef enum logic [2:0] {
    NVMSEQ_IDLE,
    NVMSEQ_INT_WRITE,
    NVMSEQ_EXT_WRITE,
    NVMSEQ_ROW_ERASE,
    NVMSEQ_BULK_ERASE
  } nvmseq_state_t;

endpackage

// ---- logic/nvmseq_addr_counter.sv ----
// Program counter of the programming mode: increment with wrap and direct load.
// Assumes commands arrive as one-cycle strobes on core_clk.
`timescale 1ns/100ps
module nvmseq_addr_counter (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic inc,
  input wire logic load,
  input wire logic [15:0] load_value,
  input wire logic [15:0] panel_mask,
  output logic [15:0] addr
);

  logic [15:0] next_addr;
  logic [15:0] incremented;

  // ----------------------------------------------------------------
  // Wrap at the top of each half
  // ----------------------------------------------------------------
  assign incremented = (addr == nvmseq_pkg::ADDR_MAIN_TOP) ? nvmseq_pkg::ADDR_RESET :
                       (addr == nvmseq_pkg::ADDR_ALL_TOP) ? nvmseq_pkg::ADDR_CONFIG_BASE :
                       addr + 16'h0001;
  assign next_addr = load ? (load_value & panel_mask) :
                     inc ? incremented : addr;

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      addr <= nvmseq_pkg::ADDR_RESET;
    end else begin
      addr <= next_addr;
    end
  end

endmodule

// ---- tb/nvmseq_core_props.sv ----
// Checker for the command sequencer: address counter, row writes, erases.
// Assumes it is bound to nvmseq_core and sees only its ports.
`timescale 1ns/100ps
module nvmseq_core_props (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic cmd_valid,
  input wire logic [5:0] cmd_code,
  input wire logic [15:0] cmd_data,
  input wire logic [15:0] panel_mask,
  input wire logic target_is_config,
  input wire logic busy,
  input wire logic [15:0] addr,
  input wire logic program_protect_n,
  input wire logic mem_write,
  input wire logic [15:0] mem_row_addr,
  input wire logic [4:0] mem_word_idx,
  input wire logic row_erase,
  input wire logic erase_pm,
  input wire logic erase_ee
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!nrst);
  // ----------------------------------------
  // Accepted command decode
  // ----------------------------------------
  wire go = cmd_valid && !busy;
  wire is_inc = go && cmd_code == nvmseq_pkg::CMD_INCREMENT;
  wire is_bi = go && cmd_code == nvmseq_pkg::CMD_BEGIN_INT;
  wire is_be = go && cmd_code == nvmseq_pkg::CMD_BEGIN_EXT;
  wire is_re = go && cmd_code == nvmseq_pkg::CMD_ROW_ERASE;
  wire known = cmd_code inside {6'h00, 6'h02, 6'h22, 6'h04, 6'h24, 6'h06, 6'h1d, 6'h08, 6'h18, 6'h0a, 6'h09, 6'h05};

  a_inc_wrap_low: assert property (is_inc && addr == 16'h7fff |=> addr == 16'h0000)
    else $error("low wrap missed");
  a_inc_wrap_high: assert property (is_inc && addr == 16'hffff |=> addr == 16'h8000)
    else $error("high wrap missed");
  a_inc_step: assert property (is_inc && addr != 16'h7fff && addr != 16'hffff |=> addr == $past(addr) + 16'h0001)
    else $error("increment wrong");
  a_load_masked: assert property (go && cmd_code == nvmseq_pkg::CMD_LOAD_ADDR |=>
    addr == ($past(cmd_data) & $past(panel_mask)))
    else $error("address load wrong");
  a_unknown_noop: assert property (go && !known |=> $stable(addr) && !busy)
    else $error("unknown code acted");
  a_begin_busy: assert property (is_bi && addr[15] |=> busy)
    else $error("internal write not started");
  a_stream_order: assert property (is_bi && addr[15:12] == 4'h8 |-> ##2 (mem_write && mem_word_idx == 5'h00 &&
    mem_row_addr[15:5] == $past(addr[15:5], 2)) ##1 (mem_write && mem_word_idx == 5'h01))
    else $error("row stream wrong");
  a_ext_cfg_quiet: assert property (is_be && target_is_config |=> !mem_write [*8])
    else $error("config word written externally");
  a_protect_block: assert property ((is_bi || is_be || is_re) && !program_protect_n && !addr[15] |=> !busy [*2])
    else $error("protected operation started");
  a_bulk_ee_only: assert property (go && cmd_code == nvmseq_pkg::CMD_BULK_ERASE && addr[15:12] == 4'hf |->
    ##[1:2] (erase_ee && !erase_pm))
    else $error("eeprom bulk erase wrong");
  a_row_erase_go: assert property (is_re && addr[15] |-> ##[1:2] row_erase)
    else $error("row erase not started");
  c_bulk: cover property (go && cmd_code == nvmseq_pkg::CMD_BULK_ERASE);
  c_ext: cover property (is_be);
  c_stream: cover property (mem_write && mem_word_idx == 5'h1f);
endmodule

// ---- tb/nvmseq_prog_model.sv ----
// Programmer model: frames six-bit commands on the serial clock.
// Assumes the framing logic hands each command over as one strobe.
`timescale 1ns/100ps
module nvmseq_prog_model (
  input wire logic core_clk,
  output logic link_clk,
  output logic cmd_valid,
  output logic [5:0] cmd_code,
  output logic [15:0] cmd_data
);
  // Shortened so the run stays short
  localparam int discharge_delay_ns = 3000;
  initial begin
    link_clk = 1'b0;
    cmd_valid = 1'b0;
    cmd_code = 6'h3f;
    cmd_data = 16'h0000;
  end
  task automatic send(input logic [5:0] code, input logic [15:0] data);
    #1.3;
    repeat (6) begin
      link_clk = 1'b1;
      #32;
      link_clk = 1'b0;
      #32;
    end
    @(negedge core_clk);
    cmd_code = code;
    cmd_data = data;
    cmd_valid = 1'b1;
    @(negedge core_clk);
    cmd_valid = 1'b0;
    cmd_code = ~code;
    cmd_data = ~data;
    #1000;
    if (code == nvmseq_pkg::CMD_END_PROG) begin
      #(discharge_delay_ns);
    end
  endtask
endmodule

// ---- tb/tb.sv ----
// Testbench of the command sequencer.
// Assumes the programmer model drives all command inputs.
`timescale 1ns/100ps
module tb;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic [15:0] panel_mask = 16'hffff;
  logic target_is_config = 1'b0;
  logic link_clk, cmd_valid, busy, link_clk_edge, mem_write, row_erase, erase_pm, erase_ee, erase_uid, erase_cfg;
  logic [5:0] cmd_code;
  logic [15:0] cmd_data, addr, mem_row_addr, rowa;
  logic [13:0] mem_word;
  logic [13:0] rdata;
  logic [13:0] got [32];
  logic [4:0] mem_word_idx;
  logic [4:0] seen = 5'h00;
  logic mon_clr = 1'b0;
  int n_errors = 0;
  int n_tests = 0;
  int n_wr = 0;
  int n_edge = 0;
  int cyc = 0;
  logic [15:0] be_addr [6] = '{16'h7fff, 16'h83ff, 16'h8400, 16'h85ff, 16'he800, 16'hffff};
  logic [3:0] be_exp [6] = '{4'b1001, 4'b1011, 4'b1010, 4'b1000, 4'b1111, 4'b0100};

  always #2 core_clk = ~core_clk;

  nvmseq_prog_model prog (.core_clk(core_clk), .link_clk(link_clk), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
    .cmd_data(cmd_data));
  nvmseq_core dut (.core_clk(core_clk), .nrst(nrst), .link_clk(link_clk), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code), .cmd_data(cmd_data), .panel_mask(panel_mask), .target_is_config(target_is_config),
    .busy(busy), .addr(addr), .read_data(rdata), .link_clk_edge(link_clk_edge), .program_protect_n(),
    .eeprom_protect_n(), .mem_write(mem_write), .mem_write_eeprom(), .mem_row_addr(mem_row_addr),
    .mem_word(mem_word), .mem_word_idx(mem_word_idx), .row_erase(row_erase), .erase_pm(erase_pm),
    .erase_ee(erase_ee), .erase_uid(erase_uid), .erase_cfg(erase_cfg), .erase_cfg4());

  // ----------------------------------------
  // Output monitor and timeout
  // ----------------------------------------
  always @(posedge core_clk) begin
    if (mon_clr) begin
      n_wr <= 0;
      n_edge <= 0;
      seen <= 5'h00;
    end else begin
      if (mem_write) begin
        got[mem_word_idx] <= mem_word;
        rowa <= mem_row_addr;
        n_wr <= n_wr + 1;
      end
      n_edge <= n_edge + int'(link_clk_edge);
      seen <= seen | {row_erase, erase_pm, erase_ee, erase_uid, erase_cfg};
    end
  end
  // About 17500 cycles of traffic expected
  always @(negedge core_clk) begin
    cyc++;
    if (cyc == 60000) begin
      n_errors++;
      results();
    end
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check(input string what, input logic [15:0] val, input logic [15:0] exp);
    n_tests++;
    if (val !== exp) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", what, exp, val);
    end
  endtask
  task automatic cmd(input logic [5:0] code, input logic [15:0] data);
    prog.send(code, data);
  endtask
  task automatic clear_mon;
    @(negedge core_clk);
    mon_clr = 1'b1;
    @(negedge core_clk);
    mon_clr = 1'b0;
  endtask
  task automatic do_reset;
    @(negedge core_clk);
    nrst = 1'b0;
    repeat (5) @(negedge core_clk);
    nrst = 1'b1;
    clear_mon();
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic test_addr;
    do_reset();
    cmd(nvmseq_pkg::CMD_LOAD_ADDR, 16'h7fff);
    cmd(nvmseq_pkg::CMD_INCREMENT, 16'h0000);
    check("low wrap", addr, 16'h0000);
    cmd(nvmseq_pkg::CMD_LOAD_ADDR, 16'hffff);
    cmd(nvmseq_pkg::CMD_INCREMENT, 16'h0000);
    check("high wrap", addr, 16'h8000);
    cmd(nvmseq_pkg::CMD_INCREMENT, 16'h0000);
    check("increment", addr, 16'h8001);
    clear_mon();
    cmd(6'h3f, 16'h1234);
    check("unknown code", addr, 16'h8001);
    check("link edges", n_edge[15:0], 16'h0006);
    panel_mask = 16'h00ff;
    cmd(nvmseq_pkg::CMD_LOAD_ADDR, 16'hf0a5);
    check("masked load", addr, 16'h00a5);
    panel_mask = 16'hffff;
    $display("address test done");
  endtask
  task automatic test_int_write;
    do_reset();
    cmd(nvmseq_pkg::CMD_LOAD_ADDR, 16'h0042);
    cmd(nvmseq_pkg::CMD_LOAD_DATA, 16'h1111);
    cmd(nvmseq_pkg::CMD_LOAD_DATA, 16'h2a2a);
    cmd(nvmseq_pkg::CMD_INCREMENT, 16'h0000);
    cmd(nvmseq_pkg::CMD_LOAD_DATA_INC, 16'h0333);
    cmd(nvmseq_pkg::CMD_LOAD_ADDR, 16'h0042);
    cmd(nvmseq_pkg::CMD_READ_DATA, 16'h0000);
    check("read latch", {2'b00, rdata}, 16'h2a2a);
    clear_mon();
    cmd(nvmseq_pkg::CMD_BEGIN_INT, 16'h0000);
    check("words streamed", n_wr[15:0], 16'h0020);
    check("overwritten latch", {2'b00, got[2]}, 16'h2a2a);
    check("next latch", {2'b00, got[3]}, 16'h0333);
    check("row address", rowa, 16'h0040);
    check("write busy", {15'h0000, busy}, 16'h0001);
    $display("internal write test done");
  endtask
  task automatic test_ext_write;
    do_reset();
    cmd(nvmseq_pkg::CMD_LOAD_ADDR, 16'h0060);
    cmd(nvmseq_pkg::CMD_LOAD_DATA, 16'h0155);
    clear_mon();
    cmd(nvmseq_pkg::CMD_BEGIN_EXT, 16'h0000);
    check("words streamed", n_wr[15:0], 16'h0020);
    check("first word", {2'b00, got[0]}, 16'h0155);
    check("pulse busy", {15'h0000, busy}, 16'h0001);
    repeat (250) @(negedge core_clk);
    cmd(nvmseq_pkg::CMD_END_PROG, 16'h0000);
    check("end releases", {15'h0000, busy}, 16'h0000);
    target_is_config = 1'b1;
    cmd(nvmseq_pkg::CMD_LOAD_CONFIG, 16'h3fff);
    repeat (7) cmd(nvmseq_pkg::CMD_INCREMENT, 16'h0000);
    check("config address", addr, 16'h8007);
    clear_mon();
    cmd(nvmseq_pkg::CMD_BEGIN_EXT, 16'h0000);
    check("config untouched", n_wr[15:0], 16'h0000);
    cmd(nvmseq_pkg::CMD_END_PROG, 16'h0000);
    target_is_config = 1'b0;
    $display("external write test done");
  endtask
  task automatic test_erase;
    for (int i = 0; i < 2; i++) begin
      do_reset();
      cmd(nvmseq_pkg::CMD_LOAD_ADDR, i == 0 ? 16'h800a : 16'h0040);
      clear_mon();
      cmd(nvmseq_pkg::CMD_ROW_ERASE, 16'h0000);
      check("row erase", {15'h0000, seen[4]}, 16'h0001);
      check("erase busy", {15'h0000, busy}, 16'h0001);
    end
    for (int i = 0; i < 6; i++) begin
      do_reset();
      cmd(nvmseq_pkg::CMD_LOAD_ADDR, be_addr[i]);
      clear_mon();
      cmd(nvmseq_pkg::CMD_BULK_ERASE, 16'h0000);
      check("bulk regions", {12'h000, seen[3:0]}, {12'h000, be_exp[i]});
      check("bulk busy", {15'h0000, busy}, 16'h0001);
    end
    $display("erase test done");
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    test_addr();
    test_int_write();
    test_ext_write();
    test_erase();
    results();
  end
endmodule

bind nvmseq_core nvmseq_core_props u_props (.core_clk(core_clk), .nrst(nrst), .cmd_valid(cmd_valid),
  .cmd_code(cmd_code), .cmd_data(cmd_data), .panel_mask(panel_mask), .target_is_config(target_is_config),
  .busy(busy), .addr(addr), .program_protect_n(program_protect_n), .mem_write(mem_write),
  .mem_row_addr(mem_row_addr), .mem_word_idx(mem_word_idx), .row_erase(row_erase), .erase_pm(erase_pm),
  .erase_ee(erase_ee));
